// ---- rtl/seto_pkg.sv ----
// Constants, bit maps and command codes for the status event and trigger-out block.
// Assumes a single 25 MHz clock and a command decoder that hands over parsed commands.
package seto_pkg;

    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned TRIG_PULSE_NS = 1000;
    localparam int unsigned TRIG_PULSE_CYCLES = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_CNT_W = 5;

    localparam int unsigned REG_W = 16;
    localparam int unsigned TRIG_LINE_COUNT = 8;

    // Activity (operation) bit positions
    localparam int unsigned ACT_CAL_BIT = 0;
    localparam int unsigned ACT_WAIT_TRIG_BIT = 5;
    localparam int unsigned ACT_CV_BIT = 8;
    localparam int unsigned ACT_CC_BIT = 10;
    localparam int unsigned ACT_STEP_BIT = 12;
    localparam logic [15:0] ACT_DEFINED = 16'h1521;
    localparam logic [15:0] ACT_PRESET_RISE = 16'h0521;

    // Anomaly (questionable) bit positions
    localparam int unsigned ANOM_OV_BIT = 0;
    localparam int unsigned ANOM_OC_BIT = 1;
    localparam int unsigned ANOM_OT_BIT = 4;
    localparam int unsigned ANOM_RI_BIT = 9;
    localparam int unsigned ANOM_UNR_BIT = 10;
    localparam logic [15:0] ANOM_DEFINED = 16'h0613;
    localparam logic [15:0] ANOM_PRESET_RISE = 16'h0613;

    // Largest value accepted by mask and filter writes
    localparam logic [15:0] MAX_MASK_VALUE = 16'h7FD7;
    localparam logic [15:0] REG_RESET = 16'h0000;

    typedef enum logic [1:0] {
        SRC_BUS,
        SRC_EXT,
        SRC_LINK,
        SRC_HOLD
    } seto_src_t;

    typedef enum logic [4:0] {
        CMD_NOP,
        CMD_TRIG_OUT_ENABLE_WR,
        CMD_TRIG_OUT_ENABLE_RD,
        CMD_TRIG_OUT_SOURCE_WR,
        CMD_TRIG_OUT_SOURCE_RD,
        CMD_TRIG_OUT_EVENT_SEL_WR,
        CMD_TRIG_OUT_EVENT_SEL_RD,
        CMD_BUS_TRIGGER,
        CMD_IMMEDIATE_TRIGGER,
        CMD_STATUS_PRESET,
        CMD_ACT_COND_RD,
        CMD_ACT_EVENT_RD,
        CMD_ACT_MASK_WR,
        CMD_ACT_MASK_RD,
        CMD_ACT_RISE_WR,
        CMD_ACT_RISE_RD,
        CMD_ACT_FALL_WR,
        CMD_ACT_FALL_RD,
        CMD_ANOM_COND_RD,
        CMD_ANOM_EVENT_RD,
        CMD_ANOM_MASK_WR,
        CMD_ANOM_MASK_RD,
        CMD_ANOM_RISE_WR,
        CMD_ANOM_RISE_RD,
        CMD_ANOM_FALL_WR,
        CMD_ANOM_FALL_RD
    } seto_cmd_t;

endpackage : seto_pkg

// ---- rtl/seto_status_group.sv ----
// One status group: condition, transition filters, latched events, enable mask, summary.
// Assumes the condition input is already synchronous to sys_clk.
module seto_status_group
    import seto_pkg::*;
#(
    parameter logic [15:0] DEFINED = 16'hFFFF,
    parameter logic [15:0] PRESET_RISE = 16'h0000
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [15:0] cond,
    input wire logic mask_wr,
    input wire logic rise_wr,
    input wire logic fall_wr,
    input wire logic [15:0] wr_data,
    input wire logic preset,
    input wire logic event_rd,
    output logic [15:0] event_bits,
    output logic [15:0] mask,
    output logic [15:0] rise_filter,
    output logic [15:0] fall_filter,
    output logic summary
);

    logic [15:0] prev_cond;
    logic [15:0] next_rise;
    logic [15:0] next_fall;
    logic [15:0] next_mask;
    logic [15:0] next_event;

    wire [15:0] rose = cond & ~prev_cond;
    wire [15:0] fell = ~cond & prev_cond;
    // Edges pass only where the matching filter bit is set
    wire [15:0] edge_hits = (rose & rise_filter) | (fell & fall_filter);

    assign next_rise = preset ? PRESET_RISE : (rise_wr ? wr_data : rise_filter);
    assign next_fall = preset ? REG_RESET : (fall_wr ? wr_data : fall_filter);
    assign next_mask = preset ? REG_RESET : (mask_wr ? wr_data : mask);

    // A newly enabled filter bit acts as if the level had just been reached
    wire [15:0] filter_hits = ((next_rise & ~rise_filter & cond)
                            | (next_fall & ~fall_filter & ~cond)) & DEFINED;

    // New hits win over the clear of a read in the same cycle
    assign next_event = ((event_rd ? REG_RESET : event_bits) | edge_hits | filter_hits)
                        & DEFINED;

    assign summary = |(event_bits & mask);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_cond <= REG_RESET;
            event_bits <= REG_RESET;
            mask <= REG_RESET;
            rise_filter <= REG_RESET;
            fall_filter <= REG_RESET;
        end else begin
            prev_cond <= cond;
            event_bits <= next_event;
            mask <= next_mask;
            rise_filter <= next_rise;
            fall_filter <= next_fall;
        end
    end

endmodule : seto_status_group

// ---- rtl/seto_status_trigger.sv ----
// Status groups for activity and anomaly reporting, plus trigger-out source selection.
// Assumes an upstream decoder presents parsed commands as one-cycle strobes on sys_clk.
// Status and trigger pins come from other domains and are synchronised here.

// Behaviour
// - Trigger-out enable, off after reset, readable back as 0 or 1.
// - Trigger-out is the OR of all module trigger lines.
// - Source is bus, backplane input, linked event or hold; bus after reset.
// - An event at the selected source sends a pulse out the trigger output.
// - Linked-event selection counts only with link source chosen; resets to off.
// - Activity bits: 0 calibrating, 5 waiting trigger, 8 CV, 10 CC, 12 step.
// - Activity condition is read-only and shows live status.
// - Activity event latches filtered changes; reading returns and clears it.
// - Status-byte bit 7 is OR of enabled activity event bits.
// - Falling filter bit set makes a 1-to-0 change set the event bit.
// - Rising filter bit makes 0-to-1 change set it; both any, neither none.
// - Writing a filter can set events for bits already at the enabled level.
// - Mask and filter registers take 0 to 32727, read back, reset to zero.
// - Preset loads rising filters 1313 and 1555, clears falling filters and masks.
// - Activity and anomaly groups each have five registers; standard group elsewhere.
// - Anomaly bits: 0 overvoltage, 1 overcurrent, 4 overtemp, 9 inhibit, 10 unregulated.
// - Status-byte bit 3 is OR of enabled anomaly event bits.
module seto_status_trigger
    import seto_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire seto_cmd_t cmd_code,
    input wire logic [15:0] cmd_data,
    output logic resp_valid,
    output logic [15:0] resp_data,
    output logic cmd_error,
    input wire logic calibrating,
    input wire logic waiting_for_trigger,
    input wire logic constant_voltage,
    input wire logic constant_current,
    input wire logic list_step_complete,
    input wire logic excess_voltage_trip,
    input wire logic excess_current_trip,
    input wire logic over_temperature,
    input wire logic remote_inhibit,
    input wire logic regulation_lost,
    input wire logic [TRIG_LINE_COUNT-1:0] trigger_line,
    input wire logic backplane_trigger_in,
    output logic trigger_out,
    output logic trigger_out_enable,
    output logic activity_summary,
    output logic anomaly_summary
);

    localparam int unsigned PIN_COUNT = 10 + TRIG_LINE_COUNT + 1;

    // Two-stage synchronisers for every pin input
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    wire [PIN_COUNT-1:0] pin_raw = {backplane_trigger_in, trigger_line,
                                    regulation_lost, remote_inhibit, over_temperature,
                                    excess_current_trip, excess_voltage_trip,
                                    list_step_complete, constant_current, constant_voltage,
                                    waiting_for_trigger, calibrating};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // Live condition vectors built from the synchronised pins
    logic [15:0] activity_condition;
    logic [15:0] anomaly_condition;

    always_comb begin
        activity_condition = REG_RESET;
        activity_condition[ACT_CAL_BIT] = pin_sync[0];
        activity_condition[ACT_WAIT_TRIG_BIT] = pin_sync[1];
        activity_condition[ACT_CV_BIT] = pin_sync[2];
        activity_condition[ACT_CC_BIT] = pin_sync[3];
        activity_condition[ACT_STEP_BIT] = pin_sync[4];
    end

    always_comb begin
        anomaly_condition = REG_RESET;
        anomaly_condition[ANOM_OV_BIT] = pin_sync[5];
        anomaly_condition[ANOM_OC_BIT] = pin_sync[6];
        anomaly_condition[ANOM_OT_BIT] = pin_sync[7];
        anomaly_condition[ANOM_RI_BIT] = pin_sync[8];
        anomaly_condition[ANOM_UNR_BIT] = pin_sync[9];
    end

    wire [TRIG_LINE_COUNT-1:0] trig_lines_sync = pin_sync[10 +: TRIG_LINE_COUNT];
    wire backplane_sync = pin_sync[PIN_COUNT-1];

    // Command decode
    wire is_cmd = cmd_valid;
    wire data_in_range = (cmd_data <= MAX_MASK_VALUE);
    wire data_is_bool = (cmd_data[15:1] == 15'h0000);
    wire data_is_source = (cmd_data[15:2] == 14'h0000);

    wire cmd_en_wr = is_cmd && (cmd_code == CMD_TRIG_OUT_ENABLE_WR);
    wire cmd_src_wr = is_cmd && (cmd_code == CMD_TRIG_OUT_SOURCE_WR);
    wire cmd_sel_wr = is_cmd && (cmd_code == CMD_TRIG_OUT_EVENT_SEL_WR);
    wire cmd_bus_trig = is_cmd && (cmd_code == CMD_BUS_TRIGGER);
    wire cmd_imm_trig = is_cmd && (cmd_code == CMD_IMMEDIATE_TRIGGER);
    wire cmd_preset = is_cmd && (cmd_code == CMD_STATUS_PRESET);

    wire cmd_act_mask = is_cmd && (cmd_code == CMD_ACT_MASK_WR);
    wire cmd_act_rise = is_cmd && (cmd_code == CMD_ACT_RISE_WR);
    wire cmd_act_fall = is_cmd && (cmd_code == CMD_ACT_FALL_WR);
    wire cmd_anom_mask = is_cmd && (cmd_code == CMD_ANOM_MASK_WR);
    wire cmd_anom_rise = is_cmd && (cmd_code == CMD_ANOM_RISE_WR);
    wire cmd_anom_fall = is_cmd && (cmd_code == CMD_ANOM_FALL_WR);
    wire cmd_group_wr = cmd_act_mask || cmd_act_rise || cmd_act_fall
                     || cmd_anom_mask || cmd_anom_rise || cmd_anom_fall;

    // Writes out of range are refused and leave the register unchanged
    wire en_wr_ok = cmd_en_wr && data_is_bool;
    wire src_wr_ok = cmd_src_wr && data_is_source;
    wire group_wr_ok = data_in_range;

    wire act_event_rd = is_cmd && (cmd_code == CMD_ACT_EVENT_RD);
    wire anom_event_rd = is_cmd && (cmd_code == CMD_ANOM_EVENT_RD);

    wire is_read = is_cmd && ((cmd_code == CMD_TRIG_OUT_ENABLE_RD)
                           || (cmd_code == CMD_TRIG_OUT_SOURCE_RD)
                           || (cmd_code == CMD_TRIG_OUT_EVENT_SEL_RD)
                           || (cmd_code == CMD_ACT_COND_RD)
                           || (cmd_code == CMD_ACT_EVENT_RD)
                           || (cmd_code == CMD_ACT_MASK_RD)
                           || (cmd_code == CMD_ACT_RISE_RD)
                           || (cmd_code == CMD_ACT_FALL_RD)
                           || (cmd_code == CMD_ANOM_COND_RD)
                           || (cmd_code == CMD_ANOM_EVENT_RD)
                           || (cmd_code == CMD_ANOM_MASK_RD)
                           || (cmd_code == CMD_ANOM_RISE_RD)
                           || (cmd_code == CMD_ANOM_FALL_RD));

    wire is_refused = (cmd_en_wr && !data_is_bool)
                   || (cmd_src_wr && !data_is_source)
                   || (cmd_group_wr && !data_in_range);

    // Trigger-out configuration registers
    seto_src_t trig_source;
    logic [15:0] trig_event_select;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            trigger_out_enable <= 1'b0;
            trig_source <= SRC_BUS;
            trig_event_select <= REG_RESET;
        end else begin
            if (en_wr_ok) begin
                trigger_out_enable <= cmd_data[0];
            end
            if (src_wr_ok) begin
                trig_source <= seto_src_t'(cmd_data[1:0]);
            end
            if (cmd_sel_wr) begin
                trig_event_select <= cmd_data & ACT_DEFINED;
            end
        end
    end

    // Source event detection
    logic backplane_q;
    logic link_hit_q;
    wire link_hit = |(activity_condition & trig_event_select);
    wire backplane_rise = backplane_sync && !backplane_q;
    wire link_rise = link_hit && !link_hit_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            backplane_q <= 1'b0;
            link_hit_q <= 1'b0;
        end else begin
            backplane_q <= backplane_sync;
            link_hit_q <= link_hit;
        end
    end

    logic source_fire;

    // Immediate trigger fires under every source, hold accepts nothing else
    always_comb begin
        case (trig_source)
            SRC_BUS: source_fire = cmd_bus_trig || cmd_imm_trig;
            SRC_EXT: source_fire = backplane_rise || cmd_imm_trig;
            SRC_LINK: source_fire = link_rise || cmd_imm_trig;
            SRC_HOLD: source_fire = cmd_imm_trig;
            default: source_fire = 1'b0;
        endcase
    end

    // Pulse stretcher for the rear trigger pulse
    logic [PULSE_CNT_W-1:0] pulse_cnt;
    logic [PULSE_CNT_W-1:0] next_pulse_cnt;
    wire pulse_active = (pulse_cnt != '0);

    assign next_pulse_cnt = source_fire ? PULSE_CNT_W'(TRIG_PULSE_CYCLES)
                          : (pulse_active ? pulse_cnt - 1'b1 : pulse_cnt);

    // Own pulse joins the module trigger lines on the shared output
    wire trig_or = pulse_active || (|trig_lines_sync);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pulse_cnt <= '0;
            trigger_out <= 1'b0;
        end else begin
            pulse_cnt <= next_pulse_cnt;
            trigger_out <= trigger_out_enable && trig_or;
        end
    end

    // Activity and anomaly status groups
    logic [15:0] act_event;
    logic [15:0] act_mask;
    logic [15:0] act_rise;
    logic [15:0] act_fall;
    logic [15:0] anom_event;
    logic [15:0] anom_mask;
    logic [15:0] anom_rise;
    logic [15:0] anom_fall;

    seto_status_group #(
        .DEFINED(ACT_DEFINED),
        .PRESET_RISE(ACT_PRESET_RISE)
    ) u_activity (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .cond(activity_condition),
        .mask_wr(cmd_act_mask && group_wr_ok),
        .rise_wr(cmd_act_rise && group_wr_ok),
        .fall_wr(cmd_act_fall && group_wr_ok),
        .wr_data(cmd_data),
        .preset(cmd_preset),
        .event_rd(act_event_rd),
        .event_bits(act_event),
        .mask(act_mask),
        .rise_filter(act_rise),
        .fall_filter(act_fall),
        .summary(activity_summary)
    );

    seto_status_group #(
        .DEFINED(ANOM_DEFINED),
        .PRESET_RISE(ANOM_PRESET_RISE)
    ) u_anomaly (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .cond(anomaly_condition),
        .mask_wr(cmd_anom_mask && group_wr_ok),
        .rise_wr(cmd_anom_rise && group_wr_ok),
        .fall_wr(cmd_anom_fall && group_wr_ok),
        .wr_data(cmd_data),
        .preset(cmd_preset),
        .event_rd(anom_event_rd),
        .event_bits(anom_event),
        .mask(anom_mask),
        .rise_filter(anom_rise),
        .fall_filter(anom_fall),
        .summary(anomaly_summary)
    );

    // Read-back selection
    logic [15:0] read_value;

    always_comb begin
        case (cmd_code)
            CMD_TRIG_OUT_ENABLE_RD: read_value = {15'h0000, trigger_out_enable};
            CMD_TRIG_OUT_SOURCE_RD: read_value = {14'h0000, trig_source};
            CMD_TRIG_OUT_EVENT_SEL_RD: read_value = trig_event_select;
            CMD_ACT_COND_RD: read_value = activity_condition;
            CMD_ACT_EVENT_RD: read_value = act_event;
            CMD_ACT_MASK_RD: read_value = act_mask;
            CMD_ACT_RISE_RD: read_value = act_rise;
            CMD_ACT_FALL_RD: read_value = act_fall;
            CMD_ANOM_COND_RD: read_value = anomaly_condition;
            CMD_ANOM_EVENT_RD: read_value = anom_event;
            CMD_ANOM_MASK_RD: read_value = anom_mask;
            CMD_ANOM_RISE_RD: read_value = anom_rise;
            CMD_ANOM_FALL_RD: read_value = anom_fall;
            default: read_value = REG_RESET;
        endcase
    end

    // Response is one cycle after the command
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            resp_valid <= 1'b0;
            resp_data <= REG_RESET;
            cmd_error <= 1'b0;
        end else begin
            resp_valid <= is_read;
            cmd_error <= is_refused;
            if (is_read) begin
                resp_data <= read_value;
            end
        end
    end

endmodule : seto_status_trigger

// ---- tb/seto_chk_sva.sv ----
// Concurrent checks on the command port and the trigger output.
// Assumes it is bound to seto_status_trigger and sees only its ports.
module seto_chk
    import seto_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire seto_cmd_t cmd_code,
    input wire logic [15:0] cmd_data,
    input wire logic resp_valid,
    input wire logic cmd_error,
    input wire logic [TRIG_LINE_COUNT-1:0] trigger_line,
    input wire logic trigger_out,
    input wire logic trigger_out_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    wire logic is_rd;
    wire logic is_mw;
    assign is_rd = cmd_code inside {CMD_TRIG_OUT_ENABLE_RD, CMD_TRIG_OUT_SOURCE_RD,
        CMD_TRIG_OUT_EVENT_SEL_RD, CMD_ACT_COND_RD, CMD_ACT_EVENT_RD, CMD_ACT_MASK_RD,
        CMD_ACT_RISE_RD, CMD_ACT_FALL_RD, CMD_ANOM_COND_RD, CMD_ANOM_EVENT_RD,
        CMD_ANOM_MASK_RD, CMD_ANOM_RISE_RD, CMD_ANOM_FALL_RD};
    assign is_mw = cmd_code inside {CMD_ACT_MASK_WR, CMD_ACT_RISE_WR, CMD_ACT_FALL_WR,
        CMD_ANOM_MASK_WR, CMD_ANOM_RISE_WR, CMD_ANOM_FALL_WR};

    read_answer_a: assert property (
        cmd_valid && is_rd |=> resp_valid) else $error("read got no answer");
    write_silent_a: assert property (
        cmd_valid && !is_rd |=> !resp_valid) else $error("answer to a non-read");
    mask_refuse_a: assert property (
        cmd_valid && is_mw && cmd_data > MAX_MASK_VALUE |=> cmd_error)
        else $error("oversize mask write not refused");
    mask_accept_a: assert property (
        cmd_valid && is_mw && cmd_data <= MAX_MASK_VALUE |=> !cmd_error)
        else $error("legal mask write refused");
    enable_write_a: assert property (
        cmd_valid && cmd_code == CMD_TRIG_OUT_ENABLE_WR && cmd_data <= 16'h0001
        |=> trigger_out_enable == $past(cmd_data[0])) else $error("enable not taken");
    enable_refuse_a: assert property (
        cmd_valid && cmd_code == CMD_TRIG_OUT_ENABLE_WR && cmd_data > 16'h0001
        |=> cmd_error && $stable(trigger_out_enable)) else $error("bad enable taken");
    source_refuse_a: assert property (
        cmd_valid && cmd_code == CMD_TRIG_OUT_SOURCE_WR && cmd_data > 16'h0003
        |=> cmd_error) else $error("bad source not refused");
    imm_pulse_a: assert property (
        cmd_valid && cmd_code == CMD_IMMEDIATE_TRIGGER && trigger_out_enable
        ##1 trigger_out_enable |=> trigger_out [*8]) else $error("no trigger pulse");
    line_or_a: assert property (
        (trigger_out_enable && (|trigger_line)) [*4] |-> trigger_out)
        else $error("trigger line not passed out");
    off_quiet_a: assert property (
        (!trigger_out_enable) [*2] |-> !trigger_out) else $error("output while disabled");
endmodule : seto_chk

bind seto_status_trigger seto_chk chk (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .cmd_data(cmd_data),
    .resp_valid(resp_valid),
    .cmd_error(cmd_error),
    .trigger_line(trigger_line),
    .trigger_out(trigger_out),
    .trigger_out_enable(trigger_out_enable)
);

// ---- tb/seto_host.sv ----
// Host controller model that hands parsed commands to the block.
// Assumes one command at a time; the bench calls xfer by hierarchical name.
module seto_host
    import seto_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resp_valid,
    input wire logic [15:0] resp_data,
    input wire logic cmd_error,
    output logic cmd_valid,
    output seto_cmd_t cmd_code,
    output logic [15:0] cmd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_NOP;
        cmd_data = 16'h0000;
    end

    // Drive on a falling edge, hold over the taking edge, sample at the next falling edge
    task automatic xfer(input seto_cmd_t code, input logic [15:0] data,
                        output logic rv, output logic [15:0] rd, output logic er);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_data = data;
        @(negedge sys_clk);
        rv = resp_valid;
        rd = resp_data;
        er = cmd_error;
        cmd_valid = 1'b0;
        cmd_data = ~data;
    endtask : xfer
endmodule : seto_host

// ---- tb/testbench.sv ----
// Self-checking bench for the status event and trigger-out block.
// Assumes the host model issues commands; the bench drives status and trigger pins.
module testbench
    import seto_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end

    logic sys_clk, sys_rst, cmd_valid, resp_valid, cmd_error, backplane_trigger_in;
    logic trigger_out, trigger_out_enable, activity_summary, anomaly_summary;
    seto_cmd_t cmd_code;
    logic [15:0] cmd_data, resp_data, rd;
    logic [4:0] act_pins, anom_pins;
    logic [7:0] trigger_line;
    logic rv, er;
    int n_fail = 0;
    int tests_run = 0;
    logic [15:0] act_w [5] = '{16'h0001, 16'h0020, 16'h0100, 16'h0400, 16'h1000};
    logic [15:0] anom_w [5] = '{16'h0001, 16'h0002, 16'h0010, 16'h0200, 16'h0400};
    seto_cmd_t zero_rd [11] = '{CMD_TRIG_OUT_ENABLE_RD, CMD_TRIG_OUT_SOURCE_RD,
        CMD_TRIG_OUT_EVENT_SEL_RD, CMD_ACT_MASK_RD, CMD_ACT_RISE_RD, CMD_ACT_FALL_RD,
        CMD_ANOM_MASK_RD, CMD_ANOM_RISE_RD, CMD_ANOM_FALL_RD, CMD_ACT_EVENT_RD,
        CMD_ACT_COND_RD};

    seto_host host (.sys_clk(sys_clk), .resp_valid(resp_valid), .resp_data(resp_data),
        .cmd_error(cmd_error), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data));

    seto_status_trigger dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .resp_valid(resp_valid),
        .resp_data(resp_data), .cmd_error(cmd_error), .calibrating(act_pins[0]),
        .waiting_for_trigger(act_pins[1]), .constant_voltage(act_pins[2]),
        .constant_current(act_pins[3]), .list_step_complete(act_pins[4]),
        .excess_voltage_trip(anom_pins[0]), .excess_current_trip(anom_pins[1]),
        .over_temperature(anom_pins[2]), .remote_inhibit(anom_pins[3]),
        .regulation_lost(anom_pins[4]), .trigger_line(trigger_line),
        .backplane_trigger_in(backplane_trigger_in), .trigger_out(trigger_out),
        .trigger_out_enable(trigger_out_enable), .activity_summary(activity_summary),
        .anomaly_summary(anomaly_summary));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : hold

    task automatic rd_chk(input seto_cmd_t c, input logic [15:0] exp);
        host.xfer(c, 16'h0000, rv, rd, er);
        `CHK(rv, 1'b1)
        `CHK(rd, exp)
    endtask : rd_chk

    task automatic wr(input seto_cmd_t c, input logic [15:0] d, input logic exp_er);
        host.xfer(c, d, rv, rd, er);
        `CHK(er, exp_er)
    endtask : wr

    // Counts trigger output cycles over a window longer than one pulse
    task automatic pulse_chk(input int exp);
        int n;
        n = 0;
        repeat (40) begin
            @(negedge sys_clk);
            if (trigger_out === 1'b1) n++;
        end
        `CHK(n, exp)
    endtask : pulse_chk

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #200us;
        n_fail++;
        $display("ERROR %0t: run did not finish", $time);
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        act_pins = 5'h00;
        anom_pins = 5'h00;
        trigger_line = 8'h00;
        backplane_trigger_in = 1'b0;
        hold(2);
        sys_rst = 1'b0;
        foreach (zero_rd[i]) rd_chk(zero_rd[i], 16'h0000);
        wr(CMD_ACT_MASK_WR, 16'h7FD7, 1'b0);
        wr(CMD_ACT_MASK_WR, 16'h7FD8, 1'b1);
        rd_chk(CMD_ACT_MASK_RD, 16'h7FD7);
        wr(CMD_ANOM_FALL_WR, 16'hFFFF, 1'b1);
        wr(CMD_TRIG_OUT_ENABLE_WR, 16'h0002, 1'b1);
        wr(CMD_TRIG_OUT_SOURCE_WR, 16'h0004, 1'b1);
        for (int i = 0; i < 5; i++) begin
            @(negedge sys_clk);
            act_pins = 5'(1 << i);
            anom_pins = 5'(1 << i);
            hold(3);
            rd_chk(CMD_ACT_COND_RD, act_w[i]);
            rd_chk(CMD_ANOM_COND_RD, anom_w[i]);
        end
        @(negedge sys_clk);
        act_pins = 5'h1F;
        anom_pins = 5'h1F;
        hold(4);
        rd_chk(CMD_ACT_EVENT_RD, 16'h0000);
        wr(CMD_ACT_RISE_WR, 16'h1521, 1'b0);
        rd_chk(CMD_ACT_EVENT_RD, 16'h1521);
        rd_chk(CMD_ACT_EVENT_RD, 16'h0000);
        wr(CMD_ACT_MASK_WR, 16'h0020, 1'b0);
        wr(CMD_ACT_FALL_WR, 16'h0020, 1'b0);
        rd_chk(CMD_ACT_EVENT_RD, 16'h0000);
        @(negedge sys_clk);
        act_pins = 5'h00;
        hold(4);
        `CHK(activity_summary, 1'b1)
        rd_chk(CMD_ACT_EVENT_RD, 16'h0020);
        `CHK(activity_summary, 1'b0)
        wr(CMD_ACT_FALL_WR, 16'h0021, 1'b0);
        rd_chk(CMD_ACT_EVENT_RD, 16'h0001);
        act_pins = 5'h01;
        hold(4);
        `CHK(activity_summary, 1'b0)
        rd_chk(CMD_ACT_EVENT_RD, 16'h0001);
        wr(CMD_ANOM_MASK_WR, 16'h0010, 1'b0);
        wr(CMD_ANOM_RISE_WR, 16'h0010, 1'b0);
        `CHK(anomaly_summary, 1'b1)
        rd_chk(CMD_ANOM_EVENT_RD, 16'h0010);
        `CHK(anomaly_summary, 1'b0)
        wr(CMD_STATUS_PRESET, 16'h0000, 1'b0);
        rd_chk(CMD_ACT_RISE_RD, 16'h0521);
        rd_chk(CMD_ACT_FALL_RD, 16'h0000);
        rd_chk(CMD_ACT_MASK_RD, 16'h0000);
        rd_chk(CMD_ANOM_RISE_RD, 16'h0613);
        rd_chk(CMD_ANOM_MASK_RD, 16'h0000);
        wr(CMD_TRIG_OUT_ENABLE_WR, 16'h0001, 1'b0);
        rd_chk(CMD_TRIG_OUT_ENABLE_RD, 16'h0001);
        for (int s = 0; s < 4; s++) begin
            wr(CMD_TRIG_OUT_SOURCE_WR, 16'(s), 1'b0);
            rd_chk(CMD_TRIG_OUT_SOURCE_RD, 16'(s));
        end
        wr(CMD_BUS_TRIGGER, 16'h0000, 1'b0);
        pulse_chk(0);
        wr(CMD_IMMEDIATE_TRIGGER, 16'h0000, 1'b0);
        pulse_chk(TRIG_PULSE_CYCLES);
        wr(CMD_TRIG_OUT_SOURCE_WR, 16'h0000, 1'b0);
        wr(CMD_BUS_TRIGGER, 16'h0000, 1'b0);
        pulse_chk(TRIG_PULSE_CYCLES);
        wr(CMD_TRIG_OUT_SOURCE_WR, 16'h0001, 1'b0);
        @(negedge sys_clk);
        backplane_trigger_in = 1'b1;
        pulse_chk(TRIG_PULSE_CYCLES);
        backplane_trigger_in = 1'b0;
        wr(CMD_TRIG_OUT_SOURCE_WR, 16'h0002, 1'b0);
        wr(CMD_TRIG_OUT_EVENT_SEL_WR, 16'h0100, 1'b0);
        rd_chk(CMD_TRIG_OUT_EVENT_SEL_RD, 16'h0100);
        @(negedge sys_clk);
        act_pins = 5'h05;
        pulse_chk(TRIG_PULSE_CYCLES);
        wr(CMD_TRIG_OUT_SOURCE_WR, 16'h0000, 1'b0);
        @(negedge sys_clk);
        act_pins = 5'h01;
        hold(4);
        act_pins = 5'h05;
        pulse_chk(0);
        for (int i = 0; i < 8; i++) begin
            trigger_line = 8'(1 << i);
            hold(4);
            `CHK(trigger_out, 1'b1)
        end
        wr(CMD_TRIG_OUT_ENABLE_WR, 16'h0000, 1'b0);
        hold(3);
        `CHK(trigger_out, 1'b0)
        trigger_line = 8'h00;
        close_out();
    end
endmodule : testbench
